// ===== cwd_config_loader.sv
`timescale 1ns/1ns
// Functional notes
// - word one bit 13 set enables the fail-safe clock monitor.
// - word one bit 12 set enables oscillator switchover.
// - word one bit 11 low drives instruction clock on clock-output pin.
// - brown-out field 11 on, 10 run only, 01 software, 00 off.
// - unimplemented configuration bits always read back as one.
// - word one bit 7 low turns program memory protection on.
// - turning code protection off erases the whole program memory.
// - reset-pin bit ignored under low-voltage entry; else one means reset.
// - power-up timer enabled by low bit five, independent of brown-out.
// - watchdog field 11 on, 10 run only, 01 software, 00 off.
// - oscillator field selects external clock, internal, RC or crystal.
// - word two bit 13 set allows low-voltage programming entry.
// - low-voltage entered session cannot clear the low-voltage enable bit.
// - word two bit 12 low dedicates serial pins to the debugger.
// - bit 11 low enables low-power brown-out; bit 10 one is low trip.
// - word two bit 9 set makes stack faults reset the device.
// - word two bit 4 low enables the regulator capacitor pin.
// - self-write field selects protected range: none, 1FFh, 1FFFh, all.
// - commands and data travel least significant bit first.
// - sender changes data on clock rise, receiver samples on fall.
// - entering program mode resets core, floats I/O, clears address.
// - configuration bits read as one when blank or bulk erased.
// - load-configuration command sets address 8000h and latches a word.
module cwd_config_loader
  import cwd_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // serial programming pins
  input wire logic I_SERIAL_PROG_CLOCK,
  input wire logic I_SERIAL_PROG_DATA,
  output logic O_SERIAL_PROG_DATA,
  output logic O_SERIAL_PROG_DATA_OE,
  // program mode entry detectors
  input wire logic I_HV_ENTRY,
  input wire logic I_LV_KEY_OK,
  // decoded settings
  output cwd_cfg_t O_CFG,
  // program mode effects
  output logic O_PROG_MODE,
  output logic O_CORE_RESET,
  output logic O_IO_HIZ,
  output logic O_PROG_MEM_ERASE,
  output logic [15:0] O_ADDR
);

  cwd_state_t s_q;
  cwd_state_t s_d;
  logic [SYNC_W-1:0] pins_sync;
  logic sclk;
  logic sdat;
  logic hv;
  logic lvkey;

  // pins come from the programmer's domain, so resynchronise them all
  cwd_sync u_sync (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_async({I_LV_KEY_OK, I_HV_ENTRY, I_SERIAL_PROG_DATA,
              I_SERIAL_PROG_CLOCK}),
    .o_sync(pins_sync)
  );

  assign sclk = pins_sync[0];
  assign sdat = pins_sync[1];
  assign hv = pins_sync[2];
  assign lvkey = pins_sync[3];

  // protected range table, scaled for the largest memory
  function automatic logic [13:0] wp_top(input logic [1:0] f);
    logic [13:0] t;
    t = WP_TOP_ALL;
    unique case (f)
      2'b11: t = 14'h0000;
      2'b10: t = WP_TOP_BOOT;
      2'b01: t = WP_TOP_HALF;
      2'b00: t = WP_TOP_ALL;
    endcase
    return t;
  endfunction

  // pure field decode; every code is legal so nothing is qualified
  function automatic cwd_cfg_t decode(input logic [13:0] w1,
                                      input logic [13:0] w2);
    cwd_cfg_t c;
    c.failsafe_clk_monitor_en = w1[CW1_FCM_BIT];
    c.osc_switchover_en = w1[CW1_SWO_BIT];
    c.clk_output_drive = !w1[CW1_CLKO_BIT];
    c.brownout_mode = cwd_en_mode_t'(w1[CW1_BOR_LSB +: 2]);
    c.code_protect_on = !w1[CW1_CP_BIT];
    // low-voltage entry keeps the pin as reset whatever bit six says
    c.ext_reset_en = w2[CW2_LVP_BIT] | w1[CW1_RSTPIN_BIT];
    // brown-out mode deliberately plays no part here
    c.powerup_timer_on = !w1[CW1_PUT_BIT];
    c.watchdog_mode = cwd_en_mode_t'(w1[CW1_WDT_LSB +: 2]);
    c.osc_mode = cwd_osc_t'(w1[CW1_OSC_LSB +: 3]);
    c.low_volt_prog_en = w2[CW2_LVP_BIT];
    c.debugger_on = !w2[CW2_DBG_BIT];
    c.low_power_brownout_on = !w2[CW2_LOW_POWER_BROWNOUT_EN_N_BIT];
    c.brownout_level_low = w2[CW2_BROWNOUT_LEVEL_SELECT_BIT];
    c.stack_fault_reset_en = w2[CW2_STK_BIT];
    c.reg_cap_on = !w2[CW2_REG_CAP_PIN_BIT];
    c.write_protect_any = (w2[CW2_WRT_LSB +: 2] != 2'b11);
    c.write_protect_top = wp_top(w2[CW2_WRT_LSB +: 2]);
    return c;
  endfunction

  // word returned by a read at the current address
  function automatic logic [13:0] read_word(input cwd_state_t s);
    logic [13:0] w;
    w = CW_BLANK;
    if (s.addr == ADDR_CW1)
      w = s.word1 | CW1_UNIMP;
    else if (s.addr == ADDR_CW2)
      w = s.word2 | CW2_UNIMP;
    else if (s.addr < ADDR_CFG_BASE && !s.word1[CW1_CP_BIT])
      w = 14'h0000;
    return w;
  endfunction

  // next-state logic for link, storage and decode capture
  always_comb
  begin
    logic rise;
    logic fall;
    logic pm;
    logic [15:0] shifted;
    logic [4:0] cmd;
    logic [13:0] nw;
    rise = 1'b0;
    fall = 1'b0;
    pm = 1'b0;
    shifted = 16'h0000;
    cmd = 5'h00;
    nw = 14'h0000;
    s_d = s_q;
    s_d.erase = 1'b0;
    rise = sclk & !s_q.clk_prev;
    fall = !sclk & s_q.clk_prev;
    s_d.clk_prev = sclk;
    shifted = {sdat, s_q.sr[15:1]};
    // low-voltage key only counts while word two allows it
    pm = hv | (lvkey & s_q.word2[CW2_LVP_BIT]);
    s_d.prog = pm;
    // core reset and I/O float follow program mode directly
    s_d.core_rst = pm;
    s_d.io_hiz = pm;
    if (pm && !s_q.prog)
    begin
      // fresh session: clear the address and the link
      s_d.addr = 16'h0000;
      s_d.st = ST_CMD;
      s_d.cnt = 5'h00;
      s_d.dat_oe = 1'b0;
      s_d.dat_o = 1'b0;
      s_d.lv_entry = !hv;
    end
    else if (!pm)
    begin
      s_d.st = ST_CMD;
      s_d.cnt = 5'h00;
      s_d.dat_oe = 1'b0;
      s_d.dat_o = 1'b0;
    end
    else if (fall)
    begin
      // every receive sample and state change happens on a clock fall
      unique case (s_q.st)
        ST_CMD:
        begin
          s_d.sr = shifted;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == CMD_BITS - 5'h01)
          begin
            s_d.cnt = 5'h00;
            // top command bit is a don't-care
            cmd = s_q.sr[15:11];
            if (cmd == CMD_LOAD_CFG)
            begin
              s_d.addr = ADDR_CFG_BASE;
              s_d.st = ST_LOAD;
            end
            else if (cmd == CMD_LOAD_DATA)
              s_d.st = ST_LOAD;
            else if (cmd == CMD_READ)
            begin
              s_d.st = ST_READ;
              s_d.sr = {2'b00, read_word(s_q)};
            end
            else if (cmd == CMD_INC_ADDR)
              s_d.addr = s_q.addr + 16'h0001;
            else if (cmd == CMD_RST_ADDR)
              s_d.addr = 16'h0000;
            else if (cmd == CMD_PROG_INT && s_q.addr == ADDR_CW1)
            begin
              nw = s_q.latch | CW1_UNIMP;
              // protection going from on to off wipes program memory
              s_d.erase = !s_q.word1[CW1_CP_BIT] & nw[CW1_CP_BIT];
              s_d.word1 = nw;
            end
            else if (cmd == CMD_PROG_INT && s_q.addr == ADDR_CW2)
            begin
              nw = s_q.latch | CW2_UNIMP;
              // a session opened by key cannot lock itself out
              if (s_q.lv_entry)
                nw[CW2_LVP_BIT] = 1'b1;
              s_d.word2 = nw;
            end
            else if (cmd == CMD_BULK_ERASE)
            begin
              s_d.word1 = CW_BLANK;
              s_d.word2 = CW_BLANK;
              s_d.erase = 1'b1;
            end
          end
        end
        ST_LOAD:
        begin
          s_d.sr = shifted;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == FRAME_BITS - 5'h01)
          begin
            // start bit ends in sr[0]; drop it and the stop bit
            s_d.latch = shifted[14:1];
            s_d.st = ST_CMD;
            s_d.cnt = 5'h00;
          end
        end
        ST_READ:
        begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00)
            s_d.dat_oe = 1'b1;
          if (s_q.cnt == FRAME_BITS - 5'h01)
          begin
            s_d.dat_oe = 1'b0;
            s_d.st = ST_CMD;
            s_d.cnt = 5'h00;
          end
        end
        default:
        begin
          s_d.st = ST_CMD;
          s_d.cnt = 5'h00;
        end
      endcase
    end
    else if (rise && s_q.st == ST_READ)
    begin
      // data bits leave on rises two to fifteen, stop bit after them
      if (s_q.cnt >= 5'h01 && s_q.cnt <= FRAME_BITS - 5'h02)
      begin
        s_d.dat_o = s_q.sr[0];
        s_d.sr = {1'b0, s_q.sr[15:1]};
      end
      else
        s_d.dat_o = 1'b0;
    end
    // settings only move while the core is held in reset
    if (!s_q.loaded || s_q.core_rst)
    begin
      s_d.cfg = decode(s_q.word1 | CW1_UNIMP, s_q.word2 | CW2_UNIMP);
      s_d.loaded = 1'b1;
    end
  end

  // words reset to blank: no real nonvolatile storage behind them
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST)
      s_q <= CWD_STATE_RST;
    else
      s_q <= s_d;
  end

  // every output straight from the state register
  assign O_SERIAL_PROG_DATA = s_q.dat_o;
  assign O_SERIAL_PROG_DATA_OE = s_q.dat_oe;
  assign O_CFG = s_q.cfg;
  assign O_PROG_MODE = s_q.prog;
  assign O_CORE_RESET = s_q.core_rst;
  assign O_IO_HIZ = s_q.io_hiz;
  assign O_PROG_MEM_ERASE = s_q.erase;
  assign O_ADDR = s_q.addr;

endmodule

// ===== cwd_pkg.sv
package cwd_pkg;

  // configuration word geometry
  localparam int CW_W = 14;
  localparam logic [13:0] CW_BLANK = 14'h3fff;
  localparam logic [13:0] CW1_UNIMP = 14'h0100;
  localparam logic [13:0] CW2_UNIMP = 14'h01ec;

  // word one field positions
  localparam int CW1_FCM_BIT = 13;
  localparam int CW1_SWO_BIT = 12;
  localparam int CW1_CLKO_BIT = 11;
  localparam int CW1_BOR_LSB = 9;
  localparam int CW1_CP_BIT = 7;
  localparam int CW1_RSTPIN_BIT = 6;
  localparam int CW1_PUT_BIT = 5;
  localparam int CW1_WDT_LSB = 3;
  localparam int CW1_OSC_LSB = 0;

  // word two field positions
  localparam int CW2_LVP_BIT = 13;
  localparam int CW2_DBG_BIT = 12;
  localparam int CW2_LOW_POWER_BROWNOUT_EN_N_BIT = 11;
  localparam int CW2_BROWNOUT_LEVEL_SELECT_BIT = 10;
  localparam int CW2_STK_BIT = 9;
  localparam int CW2_REG_CAP_PIN_BIT = 4;
  localparam int CW2_WRT_LSB = 0;

  // self-write protection limits, largest memory
  localparam logic [13:0] WP_TOP_BOOT = 14'h01ff;
  localparam logic [13:0] WP_TOP_HALF = 14'h1fff;
  localparam logic [13:0] WP_TOP_ALL = 14'h3fff;

  // serial address map
  localparam logic [15:0] ADDR_CFG_BASE = 16'h8000;
  localparam logic [15:0] ADDR_CW1 = 16'h8007;
  localparam logic [15:0] ADDR_CW2 = 16'h8008;

  // serial framing
  localparam logic [4:0] CMD_BITS = 5'h06;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_LOAD_CFG = 5'h00;
  localparam logic [4:0] CMD_LOAD_DATA = 5'h02;
  localparam logic [4:0] CMD_READ = 5'h04;
  localparam logic [4:0] CMD_INC_ADDR = 5'h06;
  localparam logic [4:0] CMD_RST_ADDR = 5'h16;
  localparam logic [4:0] CMD_PROG_INT = 5'h08;
  localparam logic [4:0] CMD_BULK_ERASE = 5'h09;

  // synchroniser width: clock, data, hv detect, lv key
  localparam int SYNC_W = 4;

  typedef enum logic [1:0] {
    EN_OFF = 2'b00,
    EN_SW = 2'b01,
    EN_RUN = 2'b10,
    EN_ON = 2'b11
  } cwd_en_mode_t;

  typedef enum logic [2:0] {
    OSC_XT_LP = 3'b000,
    OSC_XT_STD = 3'b001,
    OSC_XT_HS = 3'b010,
    OSC_RC = 3'b011,
    OSC_INT = 3'b100,
    OSC_EXT_LO = 3'b101,
    OSC_EXT_MID = 3'b110,
    OSC_EXT_HI = 3'b111
  } cwd_osc_t;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_LOAD = 2'b01,
    ST_READ = 2'b10
  } cwd_link_st_t;

  // decoded settings handed to the rest of the chip
  typedef struct packed {
    logic failsafe_clk_monitor_en;
    logic osc_switchover_en;
    logic clk_output_drive;
    cwd_en_mode_t brownout_mode;
    logic code_protect_on;
    logic ext_reset_en;
    logic powerup_timer_on;
    cwd_en_mode_t watchdog_mode;
    cwd_osc_t osc_mode;
    logic low_volt_prog_en;
    logic debugger_on;
    logic low_power_brownout_on;
    logic brownout_level_low;
    logic stack_fault_reset_en;
    logic reg_cap_on;
    logic write_protect_any;
    logic [13:0] write_protect_top;
  } cwd_cfg_t;

  typedef struct packed {
    logic [13:0] word1;
    logic [13:0] word2;
    logic [13:0] latch;
    logic [15:0] addr;
    logic [15:0] sr;
    cwd_link_st_t st;
    logic [4:0] cnt;
    logic clk_prev;
    logic lv_entry;
    logic loaded;
    cwd_cfg_t cfg;
    logic prog;
    logic core_rst;
    logic io_hiz;
    logic dat_o;
    logic dat_oe;
    logic erase;
  } cwd_state_t;

  localparam cwd_state_t CWD_STATE_RST = '{
    word1: CW_BLANK, word2: CW_BLANK, latch: CW_BLANK, addr: 16'h0000,
    sr: 16'h0000, st: ST_CMD, cnt: 5'h00, clk_prev: 1'b0,
    lv_entry: 1'b0, loaded: 1'b0, cfg: '0, prog: 1'b0,
    core_rst: 1'b1, io_hiz: 1'b1, dat_o: 1'b0, dat_oe: 1'b0,
    erase: 1'b0};

endpackage

// ===== cwd_sync.sv
`timescale 1ns/1ns
module cwd_sync
  import cwd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // asynchronous levels in, synchronous levels out
  input wire logic [SYNC_W-1:0] i_async,
  output logic [SYNC_W-1:0] o_sync
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } cwd_sync_st_t;

  cwd_sync_st_t s_q;
  cwd_sync_st_t s_d;

  // first stage feeds only the second stage
  always_comb
  begin
    s_d.meta = i_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_sync = s_q.stable;

endmodule

// ===== cwd_config_loader_monitor.sv
`timescale 1ns/1ns
module cwd_config_loader_monitor
  import cwd_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // watched pins
  input wire logic I_HV_ENTRY,
  input wire logic O_SERIAL_PROG_DATA_OE,
  input wire cwd_cfg_t O_CFG,
  input wire logic O_PROG_MODE,
  input wire logic O_CORE_RESET,
  input wire logic O_IO_HIZ,
  input wire logic O_PROG_MEM_ERASE,
  input wire logic [15:0] O_ADDR
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);

  // entry level held long enough to cross the two-flop synchroniser
  sequence s_hv_held;
    I_HV_ENTRY [*4];
  endsequence

  // core released for a few cycles, so the one late re-decode is over
  sequence s_run_quiet;
    !O_CORE_RESET [*3];
  endsequence

  // program mode entry and its side effects
  a_hv_entry: assert property (s_hv_held |=> O_PROG_MODE)
    else $error("high-voltage entry not taken");
  a_entry_state: assert property ($rose(O_PROG_MODE) |->
    O_CORE_RESET && O_IO_HIZ && O_ADDR == 16'h0000)
    else $error("entry did not reset core, float pins, clear address");
  a_prog_core_held: assert property (O_PROG_MODE |-> O_CORE_RESET)
    else $error("core runs during program mode");
  a_cfg_frozen: assert property (s_run_quiet |-> $stable(O_CFG))
    else $error("settings changed while running");
  // erase strobe is a lone pulse and only comes from a programming session
  a_erase_pulse: assert property (O_PROG_MEM_ERASE |=> !O_PROG_MEM_ERASE)
    else $error("erase strobe longer than one cycle");
  a_erase_in_prog: assert property (O_PROG_MEM_ERASE |-> O_PROG_MODE)
    else $error("erase outside program mode");
  // data pin turns round only in program mode and stays driven at least eight cycles once turned
  a_oe_in_prog: assert property (O_SERIAL_PROG_DATA_OE |-> O_PROG_MODE)
    else $error("data pin driven outside program mode");
  a_oe_stands: assert property ($rose(O_SERIAL_PROG_DATA_OE) |->
    O_SERIAL_PROG_DATA_OE [*8])
    else $error("data pin released early in a read");
  // decoded relations that hold for every stored word
  a_wp_range: assert property (O_CFG.write_protect_any ==
    (O_CFG.write_protect_top != 14'h0000))
    else $error("protect flag disagrees with protected range");
  a_lvp_rst_pin: assert property (O_CFG.low_volt_prog_en |->
    O_CFG.ext_reset_en)
    else $error("reset pin select not ignored under low-voltage entry");
endmodule

// ===== cwd_prog_model.sv
`timescale 1ns/1ns
module cwd_prog_model
(
  // device side of the data pin
  input wire logic i_dev_dat,
  input wire logic i_dev_oe,
  // programmer pins
  output logic o_sck,
  output logic o_wire
);
  logic d = 1'b0;

  // device wins while it drives; clock idles low between frames
  assign o_wire = i_dev_oe ? i_dev_dat : d;
  initial o_sck = 1'b0;

  // one bit per serial clock, lsb first; a released pin toggles every bit
  // so a stale level can never pass for the device's answer
  task automatic xfer(input logic [15:0] v, input int n, input bit rel,
    output logic [15:0] r);
    r = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      o_sck <= 1'b1;
      d <= rel ? ~d : v[k];
      #62;
      r[k] = o_wire;
      o_sck <= 1'b0;
      #63;
    end
  endtask
endmodule

// ===== tb_cwd_config_loader.sv
`timescale 1ns/1ns
module tb_cwd_config_loader;
  import cwd_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hv = 1'b0;
  logic lvk = 1'b0;
  logic sck, sdw, dout, doe, prog, crst, hiz, ers;
  cwd_cfg_t cfg;
  logic [15:0] addr;
  logic [15:0] rd;
  logic [13:0] w1, w2, pw;
  int bad_count = 0;
  int compares = 0;
  int n_ers = 0;
  int e0;

  // 125 MHz core clock
  always #4 mclk = ~mclk;

  cwd_config_loader DUT (.I_MCLK(mclk), .I_NRST(nrst),
    .I_SERIAL_PROG_CLOCK(sck), .I_SERIAL_PROG_DATA(sdw),
    .O_SERIAL_PROG_DATA(dout), .O_SERIAL_PROG_DATA_OE(doe),
    .I_HV_ENTRY(hv), .I_LV_KEY_OK(lvk), .O_CFG(cfg), .O_PROG_MODE(prog),
    .O_CORE_RESET(crst), .O_IO_HIZ(hiz), .O_PROG_MEM_ERASE(ers),
    .O_ADDR(addr));
  cwd_prog_model PRG (.i_dev_dat(dout), .i_dev_oe(doe), .o_sck(sck),
    .o_wire(sdw));

  // erase is a one-cycle strobe, so it is counted on every edge
  always @(posedge mclk)
    if (ers === 1'b1) n_ers <= n_ers + 1;

  // expected settings worked out field by field from the two words
  function automatic cwd_cfg_t dec(input logic [13:0] a, input logic [13:0] b);
    logic [13:0] top;
    top = b[1:0] == 2'b11 ? 14'h0000 : b[1:0] == 2'b10 ? WP_TOP_BOOT :
      b[1:0] == 2'b01 ? WP_TOP_HALF : WP_TOP_ALL;
    return '{a[13], a[12], !a[11], cwd_en_mode_t'(a[10:9]),
      !a[7], b[13] | a[6], !a[5], cwd_en_mode_t'(a[4:3]),
      cwd_osc_t'(a[2:0]), b[13], !b[12], !b[11], b[10],
      b[9], !b[4], b[1:0] != 2'b11, top};
  endfunction

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmd(input logic [4:0] c);
    PRG.xfer({11'h000, c}, 6, 1'b0, rd);
  endtask

  // command followed by a start bit, 14 data bits and a stop bit
  task automatic load(input logic [4:0] c, input logic [13:0] w);
    cmd(c);
    PRG.xfer({1'b0, w, 1'b0}, 16, 1'b0, rd);
  endtask

  // program the latched word, then read it back over the turned pin
  task automatic burn(input logic [13:0] e);
    cmd(CMD_PROG_INT);
    cmd(CMD_READ);
    PRG.xfer(16'h0000, 16, 1'b1, rd);
    chk(rd[15:1], {1'b0, e});
    chk(doe, 1'b0);
  endtask

  // entry levels settle through the synchroniser well within ten cycles
  task automatic entry(input logic h, input logic k);
    @(posedge mclk);
    hv <= h;
    lvk <= k;
    repeat (10) @(posedge mclk);
  endtask

  task automatic results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence: every field code, unimplemented bits written as zero
  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(cfg, dec(CW_BLANK, CW_BLANK));
    chk({prog, crst, hiz}, 3'b000);
    load(CMD_LOAD_CFG, 14'h0000);
    chk(addr, 16'h0000);
    pw = CW_BLANK;
    for (int i = 0; i < 8; i++)
    begin
      w1 = {~i[0], i[0], i[1], i[1:0], 1'b0, i[2], i[0], i[1], i[2:1], i[2:0]};
      w2 = {i < 6, i[0], i[1], i[2], ~i[0], 4'h0, i[1], 2'b00, i[1:0]};
      entry(1'b1, 1'b0);
      chk({prog, crst, hiz, addr}, {3'b111, 16'h0000});
      // program at address zero is refused; read shows protection state
      burn(pw[7] ? CW_BLANK : 14'h0000);
      load(CMD_LOAD_CFG, w1);
      chk(addr, ADDR_CFG_BASE);
      repeat (7) cmd(CMD_INC_ADDR);
      chk(addr, ADDR_CW1);
      e0 = n_ers;
      burn(w1 | CW1_UNIMP);
      cmd(CMD_INC_ADDR);
      load(CMD_LOAD_DATA, w2);
      burn(w2 | CW2_UNIMP);
      chk(n_ers - e0, pw[7] == 1'b0 && w1[7] == 1'b1);
      pw = w1;
      entry(1'b0, 1'b0);
      chk(cfg, dec(w1 | CW1_UNIMP, w2 | CW2_UNIMP));
    end
    entry(1'b0, 1'b1);
    chk(prog, 1'b0);
    entry(1'b1, 1'b0);
    cmd(CMD_RST_ADDR);
    chk(addr, 16'h0000);
    e0 = n_ers;
    cmd(CMD_BULK_ERASE);
    repeat (10) @(posedge mclk);
    chk(n_ers - e0, 1);
    entry(1'b0, 1'b0);
    chk(cfg, dec(CW_BLANK, CW_BLANK));
    entry(1'b0, 1'b1);
    chk(prog, 1'b1);
    load(CMD_LOAD_CFG, 14'h0000);
    repeat (8) cmd(CMD_INC_ADDR);
    load(CMD_LOAD_DATA, 14'h1fff);
    burn(CW_BLANK);
    entry(1'b0, 1'b0);
    results;
  end

  // watchdog: the whole sequence needs roughly 25000 cycles
  initial
  begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    results;
  end
endmodule

bind cwd_config_loader cwd_config_loader_monitor MON (.I_MCLK, .I_NRST,
  .I_HV_ENTRY, .O_SERIAL_PROG_DATA_OE, .O_CFG, .O_PROG_MODE, .O_CORE_RESET,
  .O_IO_HIZ, .O_PROG_MEM_ERASE, .O_ADDR);
